// ==== src/tsr_pkg.sv ====
package tsr_pkg;

	// ------------------------------------------------------------
	// Register map and command codes
	// ------------------------------------------------------------
	localparam logic [7:0] REG_LOCAL_TEMP  = 8'h00;
	localparam logic [7:0] REG_REMOTE_TEMP = 8'h01;
	localparam logic [7:0] REG_STATUS1     = 8'h02;
	localparam logic [7:0] REG_CFG_RD      = 8'h03;
	localparam logic [7:0] REG_RATE_RD     = 8'h04;
	localparam logic [7:0] REG_CFG_WR      = 8'h09;
	localparam logic [7:0] REG_RATE_WR     = 8'h0a;
	localparam logic [7:0] CMD_ONE_SHOT    = 8'h0f;
	localparam logic [7:0] REG_REMOTE_FRAC = 8'h10;
	localparam logic [7:0] REG_LOCAL_FRAC  = 8'h11;
	localparam logic [7:0] REG_STATUS2     = 8'h12;

	// ------------------------------------------------------------
	// Field positions, values after reset and fixed codes
	// ------------------------------------------------------------
	localparam int         CFG_STANDBY_BIT = 6;
	localparam int         CFG_CHAN_BIT    = 3;
	localparam int         STAT_FAULT_BIT  = 2;
	localparam int         STAT_BUSY_BIT   = 7;
	localparam logic [7:0] CFG_RESET       = 8'h00;
	localparam logic [7:0] RATE_RESET      = 8'h06;
	localparam logic [7:0] RATE_EXT_MAX    = 8'h05;
	localparam logic [7:0] TEMP_RESET      = 8'h00;
	localparam logic [7:0] FAULT_CODE      = 8'h80;
	localparam logic [6:0] SLAVE_ADDR_DEF  = 7'h18;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int CONV_TIME_US   = 1000;
	localparam int TIMEOUT_MS     = 25;
	localparam int CONV_CYCLES    = CONV_TIME_US * CLK_MHZ;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       cmdValid;
		logic       wrValid;
		logic       rdValid;
		logic [7:0] data;
	} tsr_bus_evt_s;

	typedef struct packed {
		logic [10:0] locTemp;
		logic [10:0] rem1Temp;
		logic [10:0] rem2Temp;
		logic        open1;
		logic        short1;
		logic        open2;
		logic        short2;
	} tsr_meas_s;

	typedef enum logic [2:0] {
		SL_IDLE     = 3'b000,
		SL_ADDR     = 3'b001,
		SL_ADDR_ACK = 3'b011,
		SL_RX       = 3'b010,
		SL_RX_ACK   = 3'b110,
		SL_TX       = 3'b111,
		SL_TX_ACK   = 3'b101
	} tsr_slave_state_e;

endpackage

// ==== src/tsr_conv_seq.sv ====
`timescale 1ns/1ps
module tsr_conv_seq #(
	parameter int CONV_CYCLES = tsr_pkg::CONV_CYCLES
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic runMode,
	input  wire logic oneShot,
	input  wire logic abort,
	output logic      busy,
	output logic      done
);

	logic [31:0] cnt_q;
	logic        busy_q;
	logic        done_q;
	wire         lastCycle = cnt_q == 32'(CONV_CYCLES - 1);

	// An abort drops the conversion without a done pulse, so results stay put.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (abort) begin
				busy_q <= 1'b0;
			end else if (busy_q) begin
				cnt_q <= cnt_q + 32'd1;
				if (lastCycle) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end else if (runMode || oneShot) begin
				busy_q <= 1'b1;
				cnt_q  <= '0;
			end
		end
	end

	assign busy = busy_q;
	assign done = done_q;

endmodule

// ==== src/tsr_smbus_slave.sv ====
`timescale 1ns/1ps
module tsr_smbus_slave #(
	parameter logic [6:0] SLAVE_ADDR     = tsr_pkg::SLAVE_ADDR_DEF,
	parameter int         TIMEOUT_CYCLES = tsr_pkg::TIMEOUT_CYCLES
) (
	input  wire logic           clk,
	input  wire logic           rstn,
	input  wire logic           sclIn,
	input  wire logic           sdaIn,
	input  wire logic           timeoutEn,
	input  wire logic [7:0]     rdData,
	output logic                sdaOeN,
	output tsr_pkg::tsr_bus_evt_s evt
);

	logic [1:0]                sclSync;
	logic [1:0]                sdaSync;
	logic                      sclPrev;
	logic                      sdaPrev;
	logic [31:0]               toCnt_q;
	tsr_pkg::tsr_slave_state_e state_q;
	logic [7:0]                shift_q;
	logic [3:0]                bitCnt_q;
	logic                      rnw_q;
	logic                      firstByte_q;
	logic                      sdaOeN_q;
	tsr_pkg::tsr_bus_evt_s     evt_q;

	wire scl       = sclSync[1];
	wire sda       = sdaSync[1];
	wire sclRise   = scl && !sclPrev;
	wire sclFall   = !scl && sclPrev;
	wire startCond = scl && sclPrev && sdaPrev && !sda;
	wire stopCond  = scl && sclPrev && !sdaPrev && sda;
	wire byteFull  = bitCnt_q == 4'd8;
	wire timedOut  = toCnt_q == 32'(TIMEOUT_CYCLES - 1);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclSync <= 2'b11;
			sdaSync <= 2'b11;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclSync <= {sclSync[0], sclIn};
			sdaSync <= {sdaSync[0], sdaIn};
			sclPrev <= sclSync[1];
			sdaPrev <= sdaSync[1];
		end
	end

	// Clock-low timeout; standby switches it off.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			toCnt_q <= '0;
		else if (!timeoutEn || scl || state_q == tsr_pkg::SL_IDLE)
			toCnt_q <= '0;
		else
			toCnt_q <= toCnt_q + 32'd1;
	end

	// ------------------------------------------------------------
	// Byte engine: sample on SCL rise, drive on SCL fall
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q     <= tsr_pkg::SL_IDLE;
			shift_q     <= '0;
			bitCnt_q    <= '0;
			rnw_q       <= 1'b0;
			firstByte_q <= 1'b0;
			sdaOeN_q    <= 1'b1;
			evt_q       <= '0;
		end else begin
			evt_q <= '0;
			if (startCond) begin
				state_q  <= tsr_pkg::SL_ADDR;
				bitCnt_q <= '0;
				sdaOeN_q <= 1'b1;
			end else if (stopCond || timedOut) begin
				state_q  <= tsr_pkg::SL_IDLE;
				sdaOeN_q <= 1'b1;
			end else if (sclRise) begin
				unique case (state_q)
					tsr_pkg::SL_ADDR, tsr_pkg::SL_RX: begin
						shift_q  <= {shift_q[6:0], sda};
						bitCnt_q <= bitCnt_q + 4'd1;
					end
					tsr_pkg::SL_TX_ACK: begin
						if (sda)
							state_q <= tsr_pkg::SL_IDLE;
					end
					default: ;
				endcase
			end else if (sclFall) begin
				unique case (state_q)
					tsr_pkg::SL_ADDR: begin
						if (byteFull && shift_q[7:1] == SLAVE_ADDR) begin
							sdaOeN_q    <= 1'b0;
							rnw_q       <= shift_q[0];
							firstByte_q <= ~shift_q[0];
							state_q     <= tsr_pkg::SL_ADDR_ACK;
						end else if (byteFull) begin
							state_q <= tsr_pkg::SL_IDLE;
						end
					end
					tsr_pkg::SL_RX: begin
						if (byteFull) begin
							sdaOeN_q       <= 1'b0;
							state_q        <= tsr_pkg::SL_RX_ACK;
							evt_q.cmdValid <= firstByte_q;
							evt_q.wrValid  <= ~firstByte_q;
							evt_q.data     <= shift_q;
							firstByte_q    <= 1'b0;
						end
					end
					tsr_pkg::SL_RX_ACK: begin
						sdaOeN_q <= 1'b1;
						bitCnt_q <= '0;
						state_q  <= tsr_pkg::SL_RX;
					end
					tsr_pkg::SL_ADDR_ACK, tsr_pkg::SL_TX_ACK: begin
						if (state_q == tsr_pkg::SL_TX_ACK || rnw_q) begin
							shift_q       <= rdData;
							sdaOeN_q      <= rdData[7];
							bitCnt_q      <= 4'd1;
							evt_q.rdValid <= 1'b1;
							state_q       <= tsr_pkg::SL_TX;
						end else begin
							sdaOeN_q <= 1'b1;
							bitCnt_q <= '0;
							state_q  <= tsr_pkg::SL_RX;
						end
					end
					tsr_pkg::SL_TX: begin
						if (byteFull) begin
							sdaOeN_q <= 1'b1;
							state_q  <= tsr_pkg::SL_TX_ACK;
						end else begin
							shift_q  <= {shift_q[6:0], 1'b0};
							sdaOeN_q <= shift_q[6];
							bitCnt_q <= bitCnt_q + 4'd1;
						end
					end
					default: ;
				endcase
			end
		end
	end

	assign sdaOeN = sdaOeN_q;
	assign evt    = evt_q;

	a_timeout_off: assert property (@(posedge clk) disable iff (!rstn)
		!timeoutEn |=> toCnt_q == '0)
		else $error("bus timeout counter ran during standby");

endmodule

// ==== src/tsr_top.sv ====
// Overview of operation
// - Standby bit set stops conversions, bus stays.
// - Standby keeps registers and bus, no timeout.
// - One-shot runs in software standby, not hardware.
// - Standby pin low overrides software conversion requests.
// - Standby during conversion aborts, old results kept.
// - All registers 8 bits, one slave address.
// - Write, read, send and receive byte transfers.
// - Receive byte returns last command-selected register.
// - Fast rates give integer two's complement temperatures.
// - Data bytes shift out most significant first.
// - Configuration bit 3 selects remote channel.
// - Slow rates add three fraction bits.
// - Main and fraction registers update together.
// - Configuration bit 6 stops or resumes running.
// - Send byte 0Fh starts one conversion.
// - Diode fault loads 80h, sets status bit 2.
// - Alert asserts for open, not shorted, diode.
// - No fault reported before first conversion ends.
// - Status read clears its channel's fault and alert request.
`timescale 1ns/1ps
module tsr_top #(
	parameter logic [6:0] SLAVE_ADDR     = tsr_pkg::SLAVE_ADDR_DEF,
	parameter int         CONV_CYCLES    = tsr_pkg::CONV_CYCLES,
	parameter int         TIMEOUT_CYCLES = tsr_pkg::TIMEOUT_CYCLES
) (
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic               smbClk,
	input  wire logic               smbDatIn,
	output logic                    smbDatOeN,
	input  wire logic               standby_pin_n,
	input  wire tsr_pkg::tsr_meas_s meas,
	output logic                    alertN
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	tsr_pkg::tsr_bus_evt_s evt;
	logic [1:0]            pinSync;
	logic                  hwPrev_q;
	logic                  swPrev_q;
	logic [7:0]            ptr_q;
	logic [7:0]            cfg_q;
	logic [7:0]            rate_q;
	logic [7:0]            locT_q;
	logic [7:0]            locF_q;
	logic [7:0]            rem1T_q;
	logic [7:0]            rem1F_q;
	logic [7:0]            rem2T_q;
	logic [7:0]            rem2F_q;
	logic                  fault1_q;
	logic                  fault2_q;
	logic                  alertReq1_q;
	logic                  alertReq2_q;
	logic                  alertN_q;
	logic                  firstDone_q;
	logic                  busy;
	logic                  done;
	logic [7:0]            rdData;

	// ------------------------------------------------------------
	// Standby control
	// ------------------------------------------------------------
	wire hwStby     = !pinSync[1];
	wire swStby     = cfg_q[tsr_pkg::CFG_STANDBY_BIT];
	wire standby    = hwStby || swStby;
	wire runMode    = !standby;
	wire cmdOneShot = evt.cmdValid && evt.data == tsr_pkg::CMD_ONE_SHOT;
	// The pin wins: a one-shot is only honoured in software standby.
	wire oneShot    = cmdOneShot && swStby && !hwStby && !busy;
	// Only a newly arriving standby request aborts; a one-shot run inside
	// software standby must not be killed by the standby that allowed it.
	wire abort      = busy && ((hwStby && !hwPrev_q) || (swStby && !swPrev_q));

	// The synchroniser resets to the pin's idle level, so reset raises no standby edge.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pinSync  <= 2'b11;
			hwPrev_q <= 1'b0;
			swPrev_q <= 1'b0;
		end else begin
			pinSync  <= {pinSync[0], standby_pin_n};
			hwPrev_q <= hwStby;
			swPrev_q <= swStby;
		end
	end

	tsr_conv_seq #(
		.CONV_CYCLES (CONV_CYCLES)
	) u_conv (
		.clk     (clk),
		.rstn    (rstn),
		.runMode (runMode),
		.oneShot (oneShot),
		.abort   (abort),
		.busy    (busy),
		.done    (done)
	);

	tsr_smbus_slave #(
		.SLAVE_ADDR     (SLAVE_ADDR),
		.TIMEOUT_CYCLES (TIMEOUT_CYCLES)
	) u_smbus (
		.clk       (clk),
		.rstn      (rstn),
		.sclIn     (smbClk),
		.sdaIn     (smbDatIn),
		.timeoutEn (!standby),
		.rdData    (rdData),
		.sdaOeN    (smbDatOeN),
		.evt       (evt)
	);

	// ------------------------------------------------------------
	// Conversion results
	// ------------------------------------------------------------
	// Slow rate codes select the extended mode that carries fraction bits.
	wire       extMode  = rate_q <= tsr_pkg::RATE_EXT_MAX;
	wire       bad1     = meas.open1 || meas.short1;
	wire       bad2     = meas.open2 || meas.short2;
	wire [7:0] locFNew  = extMode ? {meas.locTemp[2:0], 5'h00} : 8'h00;
	wire [7:0] rem1TNew = bad1 ? tsr_pkg::FAULT_CODE : meas.rem1Temp[10:3];
	wire [7:0] rem2TNew = bad2 ? tsr_pkg::FAULT_CODE : meas.rem2Temp[10:3];
	wire [7:0] rem1FNew = (extMode && !bad1) ? {meas.rem1Temp[2:0], 5'h00} : 8'h00;
	wire [7:0] rem2FNew = (extMode && !bad2) ? {meas.rem2Temp[2:0], 5'h00} : 8'h00;

	// Main and fraction bytes load on the same edge from one result.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			locT_q  <= tsr_pkg::TEMP_RESET;
			locF_q  <= tsr_pkg::TEMP_RESET;
			rem1T_q <= tsr_pkg::TEMP_RESET;
			rem1F_q <= tsr_pkg::TEMP_RESET;
			rem2T_q <= tsr_pkg::TEMP_RESET;
			rem2F_q <= tsr_pkg::TEMP_RESET;
		end else if (done) begin
			locT_q  <= meas.locTemp[10:3];
			locF_q  <= locFNew;
			rem1T_q <= rem1TNew;
			rem1F_q <= rem1FNew;
			rem2T_q <= rem2TNew;
			rem2F_q <= rem2FNew;
		end
	end

	// ------------------------------------------------------------
	// Host-written registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ptr_q  <= tsr_pkg::REG_LOCAL_TEMP;
			cfg_q  <= tsr_pkg::CFG_RESET;
			rate_q <= tsr_pkg::RATE_RESET;
		end else begin
			if (evt.cmdValid)
				ptr_q <= evt.data;
			if (evt.wrValid && ptr_q == tsr_pkg::REG_CFG_WR)
				cfg_q <= evt.data;
			if (evt.wrValid && ptr_q == tsr_pkg::REG_RATE_WR)
				rate_q <= evt.data;
		end
	end

	// ------------------------------------------------------------
	// Diode fault status and alert
	// ------------------------------------------------------------
	wire rdStat1    = evt.rdValid && ptr_q == tsr_pkg::REG_STATUS1;
	wire rdStat2    = evt.rdValid && ptr_q == tsr_pkg::REG_STATUS2;
	wire setFault1  = done && bad1;
	wire setFault2  = done && bad2;
	wire setAlert1  = done && meas.open1;
	wire setAlert2  = done && meas.open2;
	// A fault found in the very cycle of a status read survives it.
	wire fault1_d   = setFault1 || (fault1_q && !rdStat1);
	wire fault2_d   = setFault2 || (fault2_q && !rdStat2);
	wire alertReq1d = setAlert1 || (alertReq1_q && !rdStat1);
	wire alertReq2d = setAlert2 || (alertReq2_q && !rdStat2);
	// A shorted diode sets status only; the alert follows open-diode requests.
	wire alertN_d   = !(alertReq1d || alertReq2d);

	// Faults only arrive with a done pulse, so nothing shows before the first one.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fault1_q    <= 1'b0;
			fault2_q    <= 1'b0;
			alertReq1_q <= 1'b0;
			alertReq2_q <= 1'b0;
			alertN_q    <= 1'b1;
			firstDone_q <= 1'b0;
		end else begin
			fault1_q    <= fault1_d;
			fault2_q    <= fault2_d;
			alertReq1_q <= alertReq1d;
			alertReq2_q <= alertReq2d;
			alertN_q    <= alertN_d;
			firstDone_q <= firstDone_q || done;
		end
	end

	assign alertN = alertN_q;

	// ------------------------------------------------------------
	// Read selection
	// ------------------------------------------------------------
	wire       chan2     = cfg_q[tsr_pkg::CFG_CHAN_BIT];
	wire [7:0] remT      = chan2 ? rem2T_q : rem1T_q;
	wire [7:0] remF      = chan2 ? rem2F_q : rem1F_q;
	wire [7:0] stat1Byte = {busy, 4'h0, fault1_q, 2'b00};
	wire [7:0] stat2Byte = {5'h00, fault2_q, 2'b00};

	// Unmapped pointers read as zero.
	assign rdData = (ptr_q == tsr_pkg::REG_LOCAL_TEMP)  ? locT_q    :
	                (ptr_q == tsr_pkg::REG_REMOTE_TEMP) ? remT      :
	                (ptr_q == tsr_pkg::REG_STATUS1)     ? stat1Byte :
	                (ptr_q == tsr_pkg::REG_CFG_RD)      ? cfg_q     :
	                (ptr_q == tsr_pkg::REG_RATE_RD)     ? rate_q    :
	                (ptr_q == tsr_pkg::REG_REMOTE_FRAC) ? remF      :
	                (ptr_q == tsr_pkg::REG_LOCAL_FRAC)  ? locF_q    :
	                (ptr_q == tsr_pkg::REG_STATUS2)     ? stat2Byte : 8'h00;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_fault_code_load: assert property (done && bad1 |=> rem1T_q == 8'h80 && fault1_q)
		else $error("remote fault did not load fault code and status");
	a_open_alert_on: assert property (done && meas.open1 |=> !alertN_q)
		else $error("open diode did not assert alert");
	a_short_no_alert: assert property (done && meas.short1 && !meas.open1
		&& !alertReq1_q |=> !alertReq1_q)
		else $error("shorted diode raised alert");
	a_status_read_clr: assert property (rdStat1 && !setFault1 && !rdStat2
		&& !alertReq2_q && !done |=> !fault1_q && alertN_q)
		else $error("status read did not clear fault and alert");
	a_no_early_fault: assert property (!firstDone_q |-> !fault1_q && !fault2_q)
		else $error("fault reported before first conversion");
	a_abort_keeps: assert property (abort
		|=> $stable(locT_q) && $stable(rem1T_q) && !busy ##1 $stable(locF_q))
		else $error("aborted conversion changed results");
	a_hw_blocks_shot: assert property (hwStby && hwPrev_q && cmdOneShot && !busy
		|=> !busy [*2])
		else $error("one-shot started in hardware standby");
	a_sw_shot_runs: assert property (oneShot |=> busy)
		else $error("one-shot did not start in software standby");
	a_standby_idle: assert property (standby && !busy && !cmdOneShot |=> !busy)
		else $error("conversion started in standby");
	a_pair_update: assert property (done
		|=> locT_q == $past(meas.locTemp[10:3])
		&& locF_q == ($past(extMode) ? {$past(meas.locTemp[2:0]), 5'h00} : 8'h00))
		else $error("main and fraction not updated together");
	a_fast_no_frac: assert property (done && !extMode |=> locF_q == 8'h00)
		else $error("fraction bits present at fast rate");

	// The second channel, the pointer, configuration writes, conversion control and the result formats.
	a_fault2_code: assert property (done && bad2
		|=> rem2T_q == tsr_pkg::FAULT_CODE && fault2_q)
		else $error("second remote fault did not load fault code and status");
	a_alert_open2: assert property (done && meas.open2
		|=> !alertN_q)
		else $error("open second diode did not assert alert");
	a_stat2_read_clr: assert property (rdStat2 && !setFault2
		|=> !fault2_q)
		else $error("second status read did not clear fault");
	a_ptr_select: assert property (evt.cmdValid
		|=> ptr_q == $past(evt.data))
		else $error("command byte did not select the pointer");
	a_cfg_write: assert property (evt.wrValid && ptr_q == tsr_pkg::REG_CFG_WR
		|=> cfg_q == $past(evt.data))
		else $error("configuration write did not land");
	a_run_restarts: assert property (runMode && !busy |=> busy)
		else $error("conversion did not start in run mode");
	a_remote_int_fmt: assert property (done && !bad1
		|=> rem1T_q == $past(meas.rem1Temp[10:3]))
		else $error("remote integer byte not loaded from result");
	a_ext_local_frac: assert property (done && extMode
		|=> locF_q == {$past(meas.locTemp[2:0]), 5'h00})
		else $error("fraction bits missing at slow rate");
	a_frac_on_fault: assert property (done && bad1
		|=> rem1F_q == 8'h00)
		else $error("fraction bits present on a diode fault");
	a_sw_shot_single: assert property (done && swStby && !cmdOneShot
		|=> !busy)
		else $error("one-shot ran more than one conversion");
	a_abort_no_done: assert property (abort |=> !done)
		else $error("aborted conversion signalled completion");

	// ------------------------------------------------------------
	// Cover points
	// ------------------------------------------------------------
	// Each cover marks a scenario that the bench is meant to reach.
	c_conv_done: cover property (done);
	c_one_shot: cover property (oneShot ##[1:1000] done);
	c_open_alert_clr: cover property (!alertN_q ##[1:1000] rdStat1);
	c_sw_abort: cover property (busy && swStby && !swPrev_q);
	c_short_only: cover property (done && meas.short1 && !meas.open1);

endmodule

// ==== verification/tsr_host_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// SMBus host, open-drain data, data bits move only while SCL is low, start and stop move it while SCL is high
// ------------------------------------------------------------
module tsr_host_model #(
	parameter logic [6:0] ADDR = tsr_pkg::SLAVE_ADDR_DEF
) (
	input  wire logic clk,
	input  wire logic sdaWire,
	output logic      scl,
	output logic      sdaOeN
);
	int halfClk = 10;
	initial begin
		scl = 1'b1;
		sdaOeN = 1'b1;
	end
	task automatic half();
		repeat (halfClk) @(negedge clk);
	endtask
	// Start and repeated start share one sequence.
	task automatic start();
		half();
		sdaOeN = 1'b1;
		half();
		scl = 1'b1;
		half();
		sdaOeN = 1'b0;
		half();
		scl = 1'b0;
	endtask
	task automatic stop();
		half();
		sdaOeN = 1'b0;
		half();
		scl = 1'b1;
		half();
		sdaOeN = 1'b1;
		half();
	endtask
	task automatic xbit(input logic b, output logic r);
		half();
		sdaOeN = b;
		half();
		scl = 1'b1;
		half();
		r = sdaWire;
		scl = 1'b0;
	endtask
	task automatic xbyte(input logic [7:0] v, output logic [7:0] r, output logic nack);
		for (int i = 7; i >= 0; i--) begin
			xbit(v[i], r[i]);
		end
		xbit(1'b1, nack);
	endtask
	task automatic write_xfer(input logic [7:0] cmd, input logic [7:0] data,
		input logic withData, output logic nack);
		logic [7:0] d;
		logic       n0;
		logic       n1;
		logic       n2;
		start();
		xbyte({ADDR, 1'b0}, d, n0);
		xbyte(cmd, d, n1);
		n2 = 1'b0;
		if (withData) begin
			xbyte(data, d, n2);
		end
		stop();
		nack = n0 | n1 | n2;
	endtask
	task automatic read_xfer(input logic [7:0] cmd, input logic withCmd,
		output logic [7:0] data, output logic nack);
		logic [7:0] d;
		logic       n0;
		logic       n1;
		logic       n2;
		logic       n3;
		n0 = 1'b0;
		n1 = 1'b0;
		start();
		if (withCmd) begin
			xbyte({ADDR, 1'b0}, d, n0);
			xbyte(cmd, d, n1);
			start();
		end
		xbyte({ADDR, 1'b1}, d, n2);
		xbyte(8'hff, data, n3);
		stop();
		nack = n0 | n1 | n2;
	endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module tb;
	logic               clk;
	logic               rstn;
	logic               standbyPinN;
	tsr_pkg::tsr_meas_s meas;
	logic               sclW;
	logic               hostOeN;
	logic               dutOeN;
	logic               alertN;
	wire                sdaWire = hostOeN & dutOeN;
	int                 n_fail;
	int                 tests_run;

	tsr_top #(.CONV_CYCLES(50), .TIMEOUT_CYCLES(400)) dut_u (
		.clk(clk), .rstn(rstn), .smbClk(sclW), .smbDatIn(sdaWire), .smbDatOeN(dutOeN),
		.standby_pin_n(standbyPinN), .meas(meas), .alertN(alertN));
	tsr_host_model host_u (.clk(clk), .sdaWire(sdaWire), .scl(sclW), .sdaOeN(hostOeN));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input logic [7:0] mask,
		input logic withCmd);
		logic [7:0] d;
		logic       n;
		host_u.read_xfer(cmd, withCmd, d, n);
		chk("ack", 8'h00, {7'h0, n});
		chk($sformatf("reg %h", cmd), exp, d & mask);
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] data, input logic withData);
		logic n;
		host_u.write_xfer(cmd, data, withData, n);
		chk("ack", 8'h00, {7'h0, n});
	endtask
	task automatic test_hw_standby();
		wr(tsr_pkg::CMD_ONE_SHOT, 8'h00, 1'b0);
		cyc(200);
		rd(tsr_pkg::REG_STATUS1, 8'h00, 8'hff, 1'b1);
		rd(tsr_pkg::REG_LOCAL_TEMP, 8'h00, 8'hff, 1'b1);
		rd(tsr_pkg::REG_CFG_RD, 8'h00, 8'hff, 1'b1);
		rd(tsr_pkg::REG_RATE_RD, 8'h06, 8'hff, 1'b1);
		chk("alertN", 8'h01, {7'h0, alertN});
		$display("test_hw_standby done");
	endtask
	task automatic test_formats();
		meas.open1 = 1'b0;
		standbyPinN = 1'b1;
		cyc(200);
		rd(tsr_pkg::REG_LOCAL_TEMP, 8'h19, 8'hff, 1'b1);
		rd(tsr_pkg::REG_LOCAL_FRAC, 8'h00, 8'hff, 1'b1);
		wr(tsr_pkg::REG_RATE_WR, 8'h05, 1'b1);
		cyc(200);
		rd(tsr_pkg::REG_LOCAL_FRAC, 8'h40, 8'hff, 1'b1);
		rd(tsr_pkg::REG_REMOTE_TEMP, 8'h2a, 8'hff, 1'b1);
		rd(tsr_pkg::REG_REMOTE_FRAC, 8'he0, 8'hff, 1'b1);
		wr(tsr_pkg::REG_CFG_WR, 8'h08, 1'b1);
		rd(tsr_pkg::REG_REMOTE_TEMP, 8'hd5, 8'hff, 1'b1);
		rd(tsr_pkg::REG_REMOTE_FRAC, 8'h20, 8'hff, 1'b1);
		rd(8'h00, 8'h20, 8'hff, 1'b0);
		wr(tsr_pkg::REG_CFG_WR, 8'h00, 1'b1);
		$display("test_formats done");
	endtask
	task automatic test_fault();
		wr(tsr_pkg::REG_CFG_WR, 8'h40, 1'b1);
		meas.open1 = 1'b1;
		cyc(200);
		chk("alertN", 8'h01, {7'h0, alertN});
		wr(tsr_pkg::CMD_ONE_SHOT, 8'h00, 1'b0);
		cyc(200);
		chk("alertN", 8'h00, {7'h0, alertN});
		rd(tsr_pkg::REG_REMOTE_TEMP, 8'h80, 8'hff, 1'b1);
		rd(tsr_pkg::REG_STATUS1, 8'h04, 8'h04, 1'b1);
		chk("alertN", 8'h01, {7'h0, alertN});
		rd(tsr_pkg::REG_STATUS1, 8'h00, 8'h04, 1'b1);
		meas.open1 = 1'b0;
		meas.short1 = 1'b1;
		wr(tsr_pkg::CMD_ONE_SHOT, 8'h00, 1'b0);
		cyc(200);
		chk("alertN", 8'h01, {7'h0, alertN});
		rd(tsr_pkg::REG_STATUS1, 8'h04, 8'h04, 1'b1);
		meas.short1 = 1'b0;
		meas.open2 = 1'b1;
		wr(tsr_pkg::CMD_ONE_SHOT, 8'h00, 1'b0);
		cyc(200);
		chk("alertN", 8'h00, {7'h0, alertN});
		rd(tsr_pkg::REG_STATUS2, 8'h04, 8'h04, 1'b1);
		chk("alertN", 8'h01, {7'h0, alertN});
		meas.open2 = 1'b0;
		$display("test_fault done");
	endtask
	// The falling alert marks a fresh conversion, so the standby lands mid-conversion.
	task automatic test_abort();
		int k;
		host_u.halfClk = 14;
		wr(tsr_pkg::REG_CFG_WR, 8'h00, 1'b1);
		meas.open1 = 1'b1;
		for (k = 0; k < 400 && alertN !== 1'b0; k++) begin
			cyc(1);
		end
		if (k == 400) begin
			n_fail++;
			$display("unexpected alertN: expected 0, seen 1");
			tally_and_finish();
		end
		meas.locTemp = {8'h3c, 3'b000};
		standbyPinN = 1'b0;
		cyc(200);
		rd(tsr_pkg::REG_LOCAL_TEMP, 8'h19, 8'hff, 1'b1);
		// SCL low outlasts the bus timeout; standby must keep the transfer alive.
		host_u.halfClk = 220;
		rd(8'h00, 8'h19, 8'hff, 1'b0);
		host_u.halfClk = 14;
		wr(tsr_pkg::CMD_ONE_SHOT, 8'h00, 1'b0);
		cyc(200);
		rd(tsr_pkg::REG_LOCAL_TEMP, 8'h19, 8'hff, 1'b1);
		standbyPinN = 1'b1;
		cyc(200);
		rd(tsr_pkg::REG_LOCAL_TEMP, 8'h3c, 8'hff, 1'b1);
		$display("test_abort done");
	endtask

	initial begin
		rstn = 1'b0;
		standbyPinN = 1'b0;
		n_fail = 0;
		tests_run = 0;
		meas = '0;
		meas.locTemp = {8'h19, 3'b010};
		meas.rem1Temp = {8'h2a, 3'b111};
		meas.rem2Temp = {8'hd5, 3'b001};
		meas.open1 = 1'b1;
		cyc(20);
		rstn = 1'b1;
		cyc(5);
		test_hw_standby();
		test_formats();
		test_fault();
		test_abort();
		tally_and_finish();
	end
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		$display("unexpected run length: expected below 100000 cycles, seen the limit");
		tally_and_finish();
	end
endmodule
